// [pkg/laser_seq_pkg.sv]
// Constants shared by the laser enable interlock sequencer.
// Assumes a single 100 MHz core clock; all pins are asynchronous to it.
package laser_seq_pkg;
	// Clock and timing
	localparam longint unsigned CLK_PERIOD_NS = 64'd10;
	localparam longint unsigned HOLD_TIME_MS = 64'd5000;
	localparam longint unsigned NS_PER_MS = 64'd1000000;
	// Least time: round up to whole cycles
	localparam longint unsigned HOLD_CYCLES_L = (HOLD_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_CYCLES = 32'(HOLD_CYCLES_L);
	localparam int CNT_W = 29;
	// Synchroniser depth and reset values
	localparam int SYNC_STAGES = 3;
	localparam logic NEED_RESET_RST = 1'b1;
	localparam logic PIN_RST = 1'b0;
endpackage

// [src/pin_sync.sv]
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to core_clk.
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RST_VAL = laser_seq_pkg::PIN_RST
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic pin_in,
	output logic pin_out
);
	import laser_seq_pkg::*;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] stage;
		logic level;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// Shift chain; level follows once stages two and three agree
	always_comb begin
		state_next = state_reg;
		state_next.stage = {state_reg.stage[SYNC_STAGES-2:0], pin_in};
		if (state_reg.stage[1] == state_reg.stage[2]) begin
			state_next.level = state_reg.stage[2];
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '{stage: {SYNC_STAGES{RST_VAL}}, level: RST_VAL};
		end else begin
			state_reg <= state_next;
		end
	end

	assign pin_out = state_reg.level;
endmodule

// [src/laser_enable_interlock_sequencer.sv]
// Laser RF drive enable sequencer: shutter, interlock, reset/start and thermal fault.
// Assumes raw pins from optoisolators and a 100 MHz core clock.
`timescale 1ns/1ps
module laser_enable_interlock_sequencer #(
	parameter int unsigned HOLD = laser_seq_pkg::HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic oem_variant_sel,
	input wire logic shutter_switch_grounded,
	input wire logic shutter_open_request,
	input wire logic interlock_closed,
	input wire logic reset_start_request,
	input wire logic over_temp_sense,
	input wire logic pwm_command,
	output logic rf_power_on,
	output logic laser_ready,
	output logic shutter_open_indicator,
	output logic lasing_enabled,
	output logic modulation_out,
	output logic lasing_active_indicator,
	output logic interlock_open_indicator,
	output logic over_temperature_indicator
);
	import laser_seq_pkg::*;

	typedef struct packed {
		logic cfg_done;
		logic oem;
		logic need_reset;
		logic req_prev;
		logic otemp;
		logic [CNT_W-1:0] cnt;
		logic lasing_active_indicator_en;
		logic ready;
		logic shutter_open;
		logic rf_on;
		logic mod_out;
		logic int_open;
		logic temp_out;
	} seq_state_t;

	localparam seq_state_t SEQ_RST = '{cfg_done: 1'b0, oem: 1'b0, need_reset: NEED_RESET_RST,
		req_prev: 1'b0, otemp: 1'b0, cnt: '0, lasing_active_indicator_en: 1'b0, ready: 1'b0, shutter_open: 1'b0,
		rf_on: 1'b0, mod_out: 1'b0, int_open: 1'b0, temp_out: 1'b0};

	seq_state_t state_reg;
	seq_state_t state_next;
	logic shut_gnd_s;
	logic shut_req_s;
	logic intlk_s;
	logic req_s;
	logic temp_s;
	logic pwm_s;
	logic ready_c;
	logic shut_c;
	logic cond_c;

	// Pin synchronisers; every pin is asynchronous to core_clk
	// Pulses shorter than two cycles may be lost, which the sequencing tolerates
	pin_sync u_shut_gnd (.core_clk(core_clk), .resetn(resetn),
		.pin_in(shutter_switch_grounded), .pin_out(shut_gnd_s));
	pin_sync u_shut_req (.core_clk(core_clk), .resetn(resetn),
		.pin_in(shutter_open_request), .pin_out(shut_req_s));
	pin_sync u_intlk (.core_clk(core_clk), .resetn(resetn),
		.pin_in(interlock_closed), .pin_out(intlk_s));
	pin_sync u_req (.core_clk(core_clk), .resetn(resetn),
		.pin_in(reset_start_request), .pin_out(req_s));
	pin_sync u_temp (.core_clk(core_clk), .resetn(resetn),
		.pin_in(over_temp_sense), .pin_out(temp_s));
	pin_sync u_pwm (.core_clk(core_clk), .resetn(resetn),
		.pin_in(pwm_command), .pin_out(pwm_s));

	// Sequencing next state
	always_comb begin
		state_next = state_reg;
		state_next.req_prev = req_s;
		// Variant captured once, first edge after reset release
		if (!state_reg.cfg_done) begin
			state_next.oem = oem_variant_sel;
			state_next.cfg_done = 1'b1;
		end
		// Thermal fault is sticky until power cycle
		if (temp_s) begin
			state_next.otemp = 1'b1;
		end
		// Fault latch for reset toggle
		// A fault wins over a toggle seen in the same cycle
		if (state_reg.oem) begin
			state_next.need_reset = 1'b0;
		end else if (!intlk_s) begin
			state_next.need_reset = 1'b1;
		end else if (state_reg.req_prev && !req_s) begin
			state_next.need_reset = 1'b0;
		end
		// Ready and shutter status
		ready_c = state_reg.cfg_done && !state_next.need_reset && intlk_s && !req_s && !state_next.otemp;
		shut_c = !shut_gnd_s && shut_req_s;
		cond_c = ready_c && shut_c;
		// Five-second countdown restarts when any enable drops
		// Count parks at HOLD-1 once lasing is on, so it never wraps
		if (!cond_c) begin
			state_next.cnt = '0;
			state_next.lasing_active_indicator_en = 1'b0;
		end else if (!state_reg.lasing_active_indicator_en) begin
			if (state_reg.cnt == CNT_W'(HOLD - 1)) begin
				state_next.lasing_active_indicator_en = 1'b1;
			end else begin
				state_next.cnt = state_reg.cnt + CNT_W'(1);
			end
		end
		// Registered outputs
		state_next.ready = ready_c;
		state_next.shutter_open = shut_c;
		state_next.rf_on = cond_c;
		state_next.mod_out = state_next.lasing_active_indicator_en && pwm_s;
		state_next.int_open = !intlk_s;
		state_next.temp_out = temp_s;
	end

	// State register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= SEQ_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rf_power_on = state_reg.rf_on;
	assign laser_ready = state_reg.ready;
	assign shutter_open_indicator = state_reg.shutter_open;
	assign lasing_enabled = state_reg.lasing_active_indicator_en;
	assign modulation_out = state_reg.mod_out;
	assign lasing_active_indicator = state_reg.mod_out;
	assign interlock_open_indicator = state_reg.int_open;
	assign over_temperature_indicator = state_reg.temp_out;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Grounded switch forces shutter closed and RF off
	shutter_gnd_a: assert property (shut_gnd_s |=> !shutter_open_indicator && !rf_power_on)
		else $error("shutter grounded but shutter open shown");
	// RF power needs both ready and shutter open
	rf_off_a: assert property (!laser_ready || !shutter_open_indicator |-> !rf_power_on)
		else $error("rf power on without ready and shutter");
	// Keyswitch fault drops ready and arms the toggle latch
	keysw_latch_a: assert property (!state_reg.oem && state_reg.cfg_done && !intlk_s |=>
		!laser_ready && state_reg.need_reset)
		else $error("keyswitch interlock fault not latched");
	// Keyswitch toggle with interlock closed brings ready back
	rekey_ready_a: assert property (!state_reg.oem && state_reg.cfg_done && state_reg.req_prev && !req_s &&
		intlk_s && !state_reg.otemp && !temp_s |=> laser_ready)
		else $error("ready not asserted after reset toggle");
	// Thermal latch holds and keeps RF off until reset
	otemp_hold_a: assert property (state_reg.otemp |=> state_reg.otemp && !rf_power_on)
		else $error("thermal fault cleared or rf on");
	// Reset/start request holds RF off in both variants
	req_inhibit_a: assert property (req_s |=> !rf_power_on && !laser_ready)
		else $error("rf on during reset/start request");
	// Lasing only with ready and RF power present
	ready_lasing_active_indicator_a: assert property (lasing_enabled |-> laser_ready && rf_power_on)
		else $error("lasing enabled while not ready");
	// Lasing only after a full interval of enables
	count_full_a: assert property ($rose(lasing_enabled) |->
		$past(state_reg.cnt) == CNT_W'(HOLD - 1) && rf_power_on)
		else $error("lasing enabled before full interval");
	// Ready closing never enables lasing at once
	ready_wait_a: assert property ($rose(laser_ready) |-> !lasing_enabled)
		else $error("lasing enabled as ready closed");
	// Shutter opening never enables lasing at once
	shut_wait_a: assert property ($rose(shutter_open_indicator) |-> !lasing_enabled)
		else $error("lasing enabled as shutter opened");
	// Modulation passes only while lasing is enabled
	mod_gate_a: assert property (!lasing_enabled |-> !modulation_out)
		else $error("modulation passed while lasing disabled");
	// Any lost enable clears the interval
	restart_a: assert property (!cond_c |=> state_reg.cnt == '0 && !lasing_enabled)
		else $error("interval not restarted");
	// OEM ready follows the interlock without a toggle
	oem_ready_a: assert property (state_reg.oem && intlk_s && !req_s &&
		!state_reg.otemp && !temp_s |=> laser_ready)
		else $error("oem ready not reasserted");
	// Beam indicator is PWM gated by lasing enable
	lasing_active_indicator_gate_a: assert property (lasing_active_indicator == (lasing_enabled && $past(pwm_s)))
		else $error("beam indicator does not follow gated pwm");
	// Variant stays as captured after reset
	cfg_static_a: assert property (state_reg.cfg_done |=> state_reg.cfg_done && $stable(state_reg.oem))
		else $error("variant changed during operation");
	// Interlock status output
	int_out_a: assert property (!intlk_s |=> interlock_open_indicator)
		else $error("interlock open not shown");
	// Temperature status output
	temp_out_a: assert property (temp_s |=> over_temperature_indicator)
		else $error("over temperature not shown");

	// Main scenarios
	enable_c: cover property ($rose(lasing_enabled));
	fault_c: cover property (lasing_enabled ##1 !intlk_s);
	rekey_c: cover property (state_reg.need_reset ##1 !state_next.need_reset);
	otemp_c: cover property ($rose(state_reg.otemp));
	oem_rearm_c: cover property (state_reg.oem && interlock_open_indicator ##1 !interlock_open_indicator);
endmodule

// [testbench/plc_model.sv]
// Control-system model that drives the sequencer's input pins.
// Assumes the bench changes cmd just after a rising edge, one change at a time.
`timescale 1ns/1ps
module plc_model (
	input wire logic core_clk,
	input wire logic [5:0] cmd,
	output logic shutter_switch_grounded,
	output logic shutter_open_request,
	output logic interlock_closed,
	output logic reset_start_request,
	output logic over_temp_sense,
	output logic pwm_command
);
	// Pin order: grounded, request, interlock, reset/start, temp, pwm
	logic [5:0] pins_reg = 6'h18;
	// Output module takes the command word each scan; reset/start held high inhibits lasing
	always @(posedge core_clk) begin
		pins_reg <= cmd;
	end
	// Pins change only just after a rising edge
	assign {shutter_switch_grounded, shutter_open_request, interlock_closed} = pins_reg[5:3];
	assign {reset_start_request, over_temp_sense, pwm_command} = pins_reg[2:0];
endmodule

// [testbench/tb.sv]
// Self-checking bench for the laser enable interlock sequencer.
// Assumes a short countdown parameter and a six-cycle command-to-output latency.
`timescale 1ns/1ps
module tb;
	localparam int HOLD_T = 20;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic oem_variant_sel = 1'b0;
	logic sg, sr, ik, rr, ot, pw, rf, rdy, shi, len, mo, lai, ioi, oti;
	int miscompares = 0;
	int n_checks = 0;
	logic [5:0] plc_cmd = 6'h18;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s expected %b seen %b", nm, e, g); end end
	// 100 MHz clock
	always #5 core_clk = ~core_clk;
	plc_model u_plc (.core_clk(core_clk), .cmd(plc_cmd), .shutter_switch_grounded(sg), .shutter_open_request(sr),
		.interlock_closed(ik), .reset_start_request(rr), .over_temp_sense(ot), .pwm_command(pw));
	laser_enable_interlock_sequencer #(.HOLD(HOLD_T)) u_dut (.core_clk(core_clk), .resetn(resetn),
		.oem_variant_sel(oem_variant_sel), .shutter_switch_grounded(sg), .shutter_open_request(sr),
		.interlock_closed(ik), .reset_start_request(rr), .over_temp_sense(ot), .pwm_command(pw),
		.rf_power_on(rf), .laser_ready(rdy), .shutter_open_indicator(shi), .lasing_enabled(len),
		.modulation_out(mo), .lasing_active_indicator(lai), .interlock_open_indicator(ioi),
		.over_temperature_indicator(oti));
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Power cycle with a chosen variant
	task automatic rst(input logic v);
		@(posedge core_clk);
		resetn <= 1'b0;
		oem_variant_sel <= v;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
	endtask
	// New PLC command word just after a rising edge
	task automatic drive(input logic [5:0] v);
		@(posedge core_clk);
		plc_cmd <= v;
	endtask
	// Toggle the reset/start request around a base pattern
	task automatic pulse_req(input logic [5:0] b);
		drive(b | 6'h04);
		w(8);
		drive(b);
		w(8);
	endtask
	task automatic t_key;
		drive(6'h18); rst(1'b0); w(10);
		`CHK("ready", 1'b0, rdy)
		drive(6'h1c); w(10);
		`CHK("rf", 1'b0, rf)
		drive(6'h18); w(8);
		`CHK("ready", 1'b1, rdy)
		`CHK("rf", 1'b1, rf)
		`CHK("lasing", 1'b0, len)
		w(HOLD_T);
		`CHK("lasing", 1'b1, len)
		drive(6'h19); w(8);
		`CHK("mod", 1'b1, mo)
		`CHK("active", 1'b1, lai)
		$display("test keyswitch done");
	endtask
	// Grounded switch, then lost request; both restart the countdown
	task automatic t_shutter;
		logic [5:0] off[2] = '{6'h39, 6'h09};
		for (int i = 0; i < 2; i++) begin
			drive(off[i]); w(8);
			`CHK("sht", 1'b0, shi)
			`CHK("rf", 1'b0, rf)
			drive(6'h19); w(8 + HOLD_T / 2);
			`CHK("sht", 1'b1, shi)
			`CHK("mod", 1'b0, mo)
			w(HOLD_T);
			`CHK("mod", 1'b1, mo)
		end
		$display("test shutter done");
	endtask
	task automatic t_ilk_temp;
		drive(6'h11); w(8);
		`CHK("ilk", 1'b1, ioi)
		drive(6'h19); w(8);
		`CHK("ilk", 1'b0, ioi)
		`CHK("ready", 1'b0, rdy)
		pulse_req(6'h19);
		`CHK("ready", 1'b1, rdy)
		drive(6'h1b); w(8);
		`CHK("temp", 1'b1, oti)
		drive(6'h19); w(8);
		`CHK("temp", 1'b0, oti)
		pulse_req(6'h19);
		`CHK("ready", 1'b0, rdy)
		`CHK("rf", 1'b0, rf)
		$display("test interlock and temperature done");
	endtask
	task automatic t_oem;
		drive(6'h18); rst(1'b1); w(8);
		`CHK("ready", 1'b1, rdy)
		`CHK("lasing", 1'b0, len)
		w(HOLD_T);
		`CHK("lasing", 1'b1, len)
		drive(6'h10); w(8);
		`CHK("ready", 1'b0, rdy)
		drive(6'h18); w(8);
		`CHK("ready", 1'b1, rdy)
		`CHK("lasing", 1'b0, len)
		w(HOLD_T);
		`CHK("lasing", 1'b1, len)
		drive(6'h1c); w(8);
		`CHK("rf", 1'b0, rf)
		$display("test oem done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		t_key();
		t_shutter();
		t_ilk_temp();
		t_oem();
		results();
	end
	// Watchdog: tests need well under 1000 cycles
	initial begin
		#50000;
		miscompares++;
		results();
	end
endmodule
